// ===== rtl/isp_pkg.sv
// Constants and state layout for the IRQ pending, offset and sub-source block
package isp_pkg;
    localparam logic [31:0] ADDR_IRQ_PEND   = 32'h4a000010;
    localparam logic [31:0] ADDR_OFFSET     = 32'h4a000014;
    localparam logic [31:0] ADDR_SUB_PEND   = 32'h4a000018;
    localparam logic [31:0] ADDR_SUB_MASK   = 32'h4a00001c;
    localparam logic [31:0] ADDR_EVT_STATUS = 32'h4a000020;
    localparam logic [31:0] ADDR_EVT_ENABLE = 32'h4a000024;
    localparam logic [31:0] ADDR_EVT_CLEAR  = 32'h4a000028;

    localparam int          NUM_SUB         = 11;
    localparam int          NUM_EVT         = 2;
    localparam logic [4:0]  RSVD_SRC_HI     = 5'h18;
    localparam logic [4:0]  RSVD_SRC_LO     = 5'h06;

    // Sub-source field positions
    localparam int          SUB_UART0_LO    = 0;
    localparam int          SUB_UART1_LO    = 3;
    localparam int          SUB_UART2_LO    = 6;
    localparam int          SUB_TOUCH       = 9;
    localparam int          SUB_ADC         = 10;

    // Main request output positions
    localparam int          MAIN_UART0      = 0;
    localparam int          MAIN_UART1      = 1;
    localparam int          MAIN_UART2      = 2;
    localparam int          MAIN_ADC        = 3;

    // Event status bit positions
    localparam int          EVT_IRQ_LATCH   = 0;
    localparam int          EVT_SUB_RECORD  = 1;

    localparam logic [31:0] RST_IRQ_PEND    = 32'h00000000;
    localparam logic [4:0]  RST_OFFSET      = 5'h00;
    localparam logic [10:0] RST_SUB_PEND    = 11'h000;
    localparam logic [31:0] RST_SUB_MASK    = 32'h00003777;
    localparam logic [1:0]  RST_EVT         = 2'h0;

    typedef struct packed {
        logic [31:0] irq_pend;
        logic [4:0]  offset;
        logic [10:0] sub_pend;
        logic [31:0] sub_mask;
        logic [1:0]  evt_status;
        logic [1:0]  evt_enable;
        logic        irq_core;
        logic        evt_irq;
        logic [3:0]  main_req;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } isp_state_t;

    localparam isp_state_t RST_STATE = '{
        irq_pend:   RST_IRQ_PEND,
        offset:     RST_OFFSET,
        sub_pend:   RST_SUB_PEND,
        sub_mask:   RST_SUB_MASK,
        evt_status: RST_EVT,
        evt_enable: RST_EVT,
        irq_core:   1'b0,
        evt_irq:    1'b0,
        main_req:   4'h0,
        prdata:     32'h00000000,
        pready:     1'b0,
        pslverr:    1'b0
    };
endpackage

// ===== rtl/isp_irq_sub.sv
// IRQ pending, offset, sub-source pending and sub-mask block with APB slave
//
// Overview of operation
// - One pending flag per source, bits 31..0; bits 24 and 6 always read zero.
// - Offset register holds bit number of the IRQ-mode source now pending.
// - Offset returns to zero by itself once the pending flag is cleared.
// - Fast-interrupt mode sources never touch pending flags or offset.
// - Offset is read-only, resets to zero, writes ignored.
// - Sub-source pending write clears bits written one, keeps bits written zero.
// - Eleven sub-source flags at bits 10..0; bits 31..11 read zero.
// - Sub-mask one hides a sub-source from service but it stays pending.
// - Sub-mask uses the same positions and resets to the printed value.
// - At most one pending flag set, naming the source driving IRQ.
// - Software clears pending flags by writing ones, after the source flags.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
module isp_irq_sub
    import isp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        winner_valid,
    input  wire logic [4:0]  winner_num,
    input  wire logic [31:0] fiq_mode,
    input  wire logic [10:0] sub_req,
    output logic      [31:0] irq_pending_flags,
    output logic      [4:0]  irq_offset_code,
    output logic             irq_core,
    output logic      [3:0]  main_req,
    output logic             evt_irq
);
    isp_state_t st;
    isp_state_t next_st;

    logic        acc;
    logic        wr;
    logic        rd_start;
    logic [31:0] pend_kept;
    logic [31:0] win_onehot;
    logic        win_ok;
    logic [10:0] sub_new;
    logic [1:0]  evt_set;
    logic [1:0]  evt_clr;
    logic [31:0] rdata;
    logic        hit;

    assign acc = psel & penable;
    assign wr  = acc & pwrite & st.pready;

    always_comb begin
        next_st = st;

        // Bus answer comes one cycle into the access phase
        rd_start   = acc & ~st.pready;
        next_st.pready = rd_start;
        hit = 1'b1;
        case (paddr)
            ADDR_IRQ_PEND:   rdata = st.irq_pend;
            ADDR_OFFSET:     rdata = {27'h0000000, st.offset};
            ADDR_SUB_PEND:   rdata = {21'h000000, st.sub_pend};
            ADDR_SUB_MASK:   rdata = st.sub_mask;
            ADDR_EVT_STATUS: rdata = {30'h00000000, st.evt_status};
            ADDR_EVT_ENABLE: rdata = {30'h00000000, st.evt_enable};
            ADDR_EVT_CLEAR:  rdata = 32'h00000000;
            default: begin
                rdata = 32'h00000000;
                hit   = 1'b0;
            end
        endcase
        next_st.prdata  = (rd_start & ~pwrite) ? rdata : 32'h00000000;
        next_st.pslverr = rd_start & ~hit;

        // Pending flags: cleared by ones, then at most one new winner latched
        pend_kept = st.irq_pend;
        if (wr && paddr == ADDR_IRQ_PEND) begin
            pend_kept = st.irq_pend & ~pwdata;
        end
        win_onehot = 32'h00000001 << winner_num;
        win_ok = winner_valid && ((fiq_mode & win_onehot) == 32'h00000000)
               && winner_num != RSVD_SRC_HI && winner_num != RSVD_SRC_LO;
        if (pend_kept == 32'h00000000 && win_ok) begin
            next_st.irq_pend = win_onehot;
            next_st.offset   = winner_num;
        end else begin
            next_st.irq_pend = pend_kept;
            if (pend_kept == 32'h00000000) begin
                next_st.offset = RST_OFFSET;
            end
        end
        next_st.irq_core = next_st.irq_pend != 32'h00000000;

        // Sub-source pending: a new request wins over a same-cycle clear
        next_st.sub_pend = st.sub_pend;
        if (wr && paddr == ADDR_SUB_PEND) begin
            next_st.sub_pend = st.sub_pend & ~pwdata[10:0];
        end
        sub_new = sub_req & ~st.sub_pend;
        next_st.sub_pend = next_st.sub_pend | sub_req;

        if (wr && paddr == ADDR_SUB_MASK) begin
            next_st.sub_mask = pwdata;
        end

        next_st.main_req[MAIN_UART0] = |(next_st.sub_pend[SUB_UART0_LO +: 3]
                                        & ~next_st.sub_mask[SUB_UART0_LO +: 3]);
        next_st.main_req[MAIN_UART1] = |(next_st.sub_pend[SUB_UART1_LO +: 3]
                                        & ~next_st.sub_mask[SUB_UART1_LO +: 3]);
        next_st.main_req[MAIN_UART2] = |(next_st.sub_pend[SUB_UART2_LO +: 3]
                                        & ~next_st.sub_mask[SUB_UART2_LO +: 3]);
        next_st.main_req[MAIN_ADC] = (next_st.sub_pend[SUB_ADC] & ~next_st.sub_mask[SUB_ADC])
                                   | (next_st.sub_pend[SUB_TOUCH] & ~next_st.sub_mask[SUB_TOUCH]);

        // Event status: set wins over clear
        evt_set = 2'h0;
        evt_set[EVT_IRQ_LATCH]  = st.irq_pend == 32'h00000000 && next_st.irq_pend != 32'h00000000;
        evt_set[EVT_SUB_RECORD] = sub_new != 11'h000;
        evt_clr = (wr && paddr == ADDR_EVT_CLEAR) ? pwdata[1:0] : 2'h0;
        next_st.evt_status = (st.evt_status & ~evt_clr) | evt_set;
        if (wr && paddr == ADDR_EVT_ENABLE) begin
            next_st.evt_enable = pwdata[1:0];
        end
        next_st.evt_irq = (next_st.evt_status & next_st.evt_enable) != 2'h0;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= RST_STATE;
        end else begin
            st <= next_st;
        end
    end

    assign prdata            = st.prdata;
    assign pready            = st.pready;
    assign pslverr           = st.pslverr;
    assign irq_pending_flags = st.irq_pend;
    assign irq_offset_code   = st.offset;
    assign irq_core          = st.irq_core;
    assign main_req          = st.main_req;
    assign evt_irq           = st.evt_irq;

    // Checks
    sequence access_start_s;
        psel && penable && !pready;
    endsequence

    sequence answer_s;
        pready ##1 !pready;
    endsequence

    sequence pend_write_s;
        psel && penable && pready && pwrite && paddr == ADDR_IRQ_PEND && pwdata[0];
    endsequence

    pend_onehot_a: assert property (@(posedge clk) disable iff (rst)
        $onehot0(irq_pending_flags)) else $error("more than one pending flag");

    reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
        !irq_pending_flags[24] && !irq_pending_flags[6]) else $error("reserved flag set");

    offset_match_a: assert property (@(posedge clk) disable iff (rst)
        irq_core |-> irq_pending_flags[irq_offset_code]) else $error("offset mismatch");

    offset_idle_a: assert property (@(posedge clk) disable iff (rst)
        !irq_core |-> irq_offset_code == 5'h00) else $error("offset not zero");

    fiq_ignore_a: assert property (@(posedge clk) disable iff (rst)
        (!irq_core && winner_valid && fiq_mode[winner_num]) |=> !irq_core)
        else $error("fast source entered pending");

    offset_ro_a: assert property (@(posedge clk) disable iff (rst)
        (psel && penable && pready && pwrite && paddr == ADDR_OFFSET && irq_core
         && !(psel && penable && pready && pwrite && paddr == ADDR_IRQ_PEND))
        |=> $stable(irq_offset_code)) else $error("offset changed by write");

    sub_clear_a: assert property (@(posedge clk) disable iff (rst)
        (psel && penable && pready && pwrite && paddr == ADDR_SUB_PEND && pwdata[0]
         && !sub_req[0]) |=> !st.sub_pend[0]) else $error("sub flag not cleared");

    sub_read_a: assert property (@(posedge clk) disable iff (rst)
        (access_start_s and (!pwrite && paddr == ADDR_SUB_PEND)) |=> prdata[31:11] == 21'h0)
        else $error("sub upper bits not zero");

    main_gate_a: assert property (@(posedge clk) disable iff (rst)
        main_req[MAIN_UART0] == |(st.sub_pend[2:0] & ~st.sub_mask[2:0]))
        else $error("main request gating wrong");

    mask_reset_a: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> st.sub_mask == RST_SUB_MASK) else $error("sub mask reset wrong");

    pend_clear_a: assert property (@(posedge clk) disable iff (rst)
        (pend_write_s and !winner_valid) |=> !irq_pending_flags[0])
        else $error("pending flag not cleared");

    apb_answer_a: assert property (@(posedge clk) disable iff (rst)
        access_start_s |=> answer_s) else $error("bus answer timing wrong");
endmodule

// ===== bench/isp_src_model.sv
// Model of the priority logic and peripheral request lines feeding the block
`timescale 1ns/10ps
module isp_src_model (
    input  wire logic        clk,
    output logic             winner_valid,
    output logic      [4:0]  winner_num,
    output logic      [31:0] fiq_mode,
    output logic      [10:0] sub_req
);
    initial begin
        winner_valid = 1'b0;
        winner_num = 5'h1f;
        fiq_mode = 32'h00000000;
        sub_req = 11'h000;
    end
    // With no candidate the number lines carry no stable value
    task offer(input logic v, input logic [4:0] n, input logic [31:0] f);
        @(posedge clk);
        winner_valid <= v;
        winner_num <= v ? n : ~winner_num;
        fiq_mode <= f;
    endtask
    task pulse_sub(input logic [10:0] b);
        @(posedge clk);
        sub_req <= b;
        @(posedge clk);
        sub_req <= 11'h000;
    endtask
endmodule

// ===== bench/tb_isp_irq_sub.sv
// Self-checking bench for the IRQ pending, offset and sub-source block
`timescale 1ns/10ps
module tb_isp_irq_sub;
    import isp_pkg::*;
    logic        clk, rst, psel, penable, pwrite, pslverr, pready, irq_core, evt_irq;
    logic        winner_valid, rerr;
    logic [31:0] paddr, pwdata, prdata, fiq_mode, irq_pending_flags, rdat;
    logic [4:0]  winner_num, irq_offset_code;
    logic [10:0] sub_req;
    logic [3:0]  main_req;
    int          failures, samples_checked;

    isp_irq_sub i_isp_irq_sub (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .winner_valid(winner_valid), .winner_num(winner_num),
        .fiq_mode(fiq_mode), .sub_req(sub_req), .irq_pending_flags(irq_pending_flags),
        .irq_offset_code(irq_offset_code), .irq_core(irq_core), .main_req(main_req),
        .evt_irq(evt_irq));
    isp_src_model i_isp_src_model (.clk(clk), .winner_valid(winner_valid),
        .winner_num(winner_num), .fiq_mode(fiq_mode), .sub_req(sub_req));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task conclude;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // Request stands until pready is seen high at a rising edge
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            conclude();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input string name, input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(name, rdat, exp);
    endtask

    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task t_reset;
        rd("offset", ADDR_OFFSET, 32'h00000000);
        rd("sub pend", ADDR_SUB_PEND, 32'h00000000);
        rd("sub mask", ADDR_SUB_MASK, 32'h00003777);
        rd("irq pend", ADDR_IRQ_PEND, 32'h00000000);
    endtask

    task t_latch(input logic [4:0] n);
        i_isp_src_model.offer(1'b1, n, 32'h00000000);
        settle();
        i_isp_src_model.offer(1'b0, 5'h00, 32'h00000000);
        chk("flags", irq_pending_flags, 32'h00000001 << n);
        chk("irq core", {31'h0, irq_core}, 32'h00000001);
        rd("offset", ADDR_OFFSET, {27'h0, n});
        apb(1'b1, ADDR_OFFSET, ~{27'h0, n});
        rd("offset kept", ADDR_OFFSET, {27'h0, n});
        apb(1'b1, ADDR_IRQ_PEND, ~(32'h00000001 << n));
        rd("flags kept", ADDR_IRQ_PEND, 32'h00000001 << n);
        apb(1'b1, ADDR_IRQ_PEND, 32'h00000001 << n);
        settle();
        chk("flags clear", irq_pending_flags, 32'h00000000);
        chk("offset clear", {27'h0, irq_offset_code}, 32'h00000000);
        chk("irq core off", {31'h0, irq_core}, 32'h00000000);
    endtask

    task t_excl(input logic [4:0] n, input logic [31:0] f);
        i_isp_src_model.offer(1'b1, n, f);
        settle();
        i_isp_src_model.offer(1'b0, 5'h00, 32'h00000000);
        chk("no flag", irq_pending_flags, 32'h00000000);
        rd("no offset", ADDR_OFFSET, 32'h00000000);
    endtask

    task mask_main(input logic [31:0] m, input logic [3:0] exp);
        apb(1'b1, ADDR_SUB_MASK, m);
        settle();
        chk("main req", {28'h0, main_req}, {28'h0, exp});
    endtask

    task t_sub;
        i_isp_src_model.pulse_sub(11'h7ff);
        settle();
        chk("main req", {28'h0, main_req}, 32'h00000006);
        mask_main(32'h000007ff, 4'h0);
        rd("sub pend", ADDR_SUB_PEND, 32'h000007ff);
        mask_main(32'h00000000, 4'hf);
        apb(1'b1, ADDR_SUB_PEND, 32'h000001ff);
        rd("sub w1c", ADDR_SUB_PEND, 32'h00000600);
        settle();
        chk("main adc", {28'h0, main_req}, 32'h00000008);
        apb(1'b1, ADDR_SUB_PEND, 32'hffffffff);
        rd("sub empty", ADDR_SUB_PEND, 32'h00000000);
    endtask

    task t_evt;
        apb(1'b1, ADDR_EVT_ENABLE, 32'h00000000);
        settle();
        chk("evt masked", {31'h0, evt_irq}, 32'h00000000);
        apb(1'b1, ADDR_EVT_ENABLE, 32'h00000003);
        settle();
        chk("evt on", {31'h0, evt_irq}, 32'h00000001);
        rd("evt status", ADDR_EVT_STATUS, 32'h00000003);
        apb(1'b1, ADDR_EVT_CLEAR, 32'h00000003);
        settle();
        chk("evt off", {31'h0, evt_irq}, 32'h00000000);
        rd("unmapped", 32'h4a000030, 32'h00000000);
        chk("slverr", {31'h0, rerr}, 32'h00000001);
    endtask

    initial begin
        failures = 0;
        samples_checked = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_latch(5'h1c);
        t_latch(5'h1f);
        t_latch(5'h00);
        t_excl(RSVD_SRC_HI, 32'h00000000);
        t_excl(5'h05, 32'h00000020);
        t_sub();
        t_evt();
        conclude();
    end
endmodule
